// File: rtl/icr_pkg.sv
package icr_pkg;

   // avalon byte offsets, one aligned word each
   localparam logic [4:0] OFF_MAIN = 5'h00;
   localparam logic [4:0] OFF_SECOND = 5'h04;
   localparam logic [4:0] OFF_STATUS = 5'h08;
   localparam logic [4:0] OFF_MASK = 5'h0C;

   localparam int unsigned REG_W = 8;
   localparam int unsigned EV_W = 3;
   localparam int unsigned PB_W = 4;

   // main control register fields
   localparam int unsigned B_GIE_HIGH = 7;
   localparam int unsigned B_PERIPH_LOW = 6;
   localparam int unsigned B_T0_EN = 5;
   localparam int unsigned B_E0_EN = 4;
   localparam int unsigned B_PC_EN = 3;
   localparam int unsigned B_T0_FLAG = 2;
   localparam int unsigned B_E0_FLAG = 1;
   localparam int unsigned B_PC_FLAG = 0;

   // second control register fields
   localparam int unsigned B_PULLUP_DIS = 7;
   localparam int unsigned B_E0_EDGE = 6;
   localparam int unsigned B_E1_EDGE = 5;
   localparam int unsigned B_T0_PRIO = 2;
   localparam int unsigned B_PC_PRIO = 0;

   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam logic [7:0] SECOND_RST = 8'hE5;
   localparam logic [7:0] SECOND_IMPL = 8'hE5;

   // sticky status / mask layout
   localparam int unsigned ST_T0 = 0;
   localparam int unsigned ST_E0 = 1;
   localparam int unsigned ST_PC = 2;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      ICR_BUS_IDLE = 2'b01,
      ICR_BUS_ACK = 2'b10
   } icr_bus_state_t;

endpackage

// File: rtl/icr_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface icr_edge_if;
   logic level;
   logic rise_sel;
   logic hit;
   modport det (input level, input rise_sel, output hit);
   modport ctl (output level, output rise_sel, input hit);
endinterface
`default_nettype wire

// File: rtl/icr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module icr_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule
`default_nettype wire

// File: rtl/icr_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module icr_edge_det (
   input wire logic clk,
   input wire logic rst_n,
   icr_edge_if.det e
);
   logic prev_q;
   logic prev_d;
   logic [2:0] arm_q;
   logic [2:0] arm_d;

   always_comb begin
      prev_d = e.level;
      arm_d = {arm_q[1:0], 1'b1};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         arm_q <= 3'h0;
      end else begin
         prev_q <= prev_d;
         arm_q <= arm_d;
      end
   end

   // synchroniser resets low; a pin idling high would look like a rising edge
   // until both the synced level and the previous level hold real pin values
   assign e.hit = arm_q[2] & (e.rise_sel ? (e.level & ~prev_q) : (~e.level & prev_q));
endmodule
`default_nettype wire

// File: rtl/icr_top.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module icr_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic timer0_overflow,
   input wire logic ext0_pin,
   input wire logic [3:0] port_b_a_upper,
   input wire logic port_b_read,
   input wire logic [7:0] port_b_latch,
   input wire logic priority_mode_enable,
   input wire logic periph_pend_high,
   input wire logic periph_pend_low,
   input wire logic irq_taken,
   input wire logic irq_taken_high,
   output logic irq_req_high,
   output logic irq_req_low,
   output logic [7:0] port_b_pullup_en,
   output logic ext1_edge_select,
   output logic irq
);

   // pin synchronisers
   logic [4:0] pin_raw;
   logic [4:0] pin_sync;
   logic ext0_lvl;
   logic [3:0] pb_sync;

   assign pin_raw = {ext0_pin, port_b_a_upper};

   icr_sync #(
      .W(5)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(pin_raw),
      .dout(pin_sync)
   );

   assign ext0_lvl = pin_sync[4];
   assign pb_sync = pin_sync[3:0];

   // register state
   logic [7:0] main_q;
   logic [7:0] main_d;
   logic [7:0] second_q;
   logic [7:0] second_d;
   logic [2:0] status_q;
   logic [2:0] status_d;
   logic [2:0] mask_q;
   logic [2:0] mask_d;
   logic [3:0] snap_q;
   logic [3:0] snap_d;
   logic mism_q;
   logic mism_d;

   // ext0 edge detection
   icr_edge_if ext0_e ();

   assign ext0_e.level = ext0_lvl;
   assign ext0_e.rise_sel = second_q[icr_pkg::B_E0_EDGE];

   icr_edge_det u_ext0 (
      .clk(clk),
      .rst_n(rst_n),
      .e(ext0_e)
   );

   // bus slave state
   icr_pkg::icr_bus_state_t bus_q;
   icr_pkg::icr_bus_state_t bus_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic req_v;
   logic acked;
   logic sel_main;
   logic sel_second;
   logic sel_status;
   logic sel_mask;
   logic wr_fire;
   logic [7:0] wd;
   logic [7:0] rd_mux;

   assign req_v = avs_read | avs_write;
   assign acked = (bus_q == icr_pkg::ICR_BUS_ACK);
   assign avs_waitrequest = req_v & ~acked;
   assign wr_fire = avs_write & acked & avs_byteenable[0];
   assign wd = avs_writedata[7:0];

   assign sel_main = (avs_address == icr_pkg::OFF_MAIN);
   assign sel_second = (avs_address == icr_pkg::OFF_SECOND);
   assign sel_status = (avs_address == icr_pkg::OFF_STATUS);
   assign sel_mask = (avs_address == icr_pkg::OFF_MASK);

   // readback; unmapped offsets read zero
   always_comb begin
      rd_mux = 8'h00;
      if (sel_main) begin
         rd_mux = main_q;
      end else if (sel_second) begin
         rd_mux = second_q & icr_pkg::SECOND_IMPL;
      end else if (sel_status) begin
         rd_mux = {5'h00, status_q};
      end else if (sel_mask) begin
         rd_mux = {5'h00, mask_q};
      end
   end

   always_comb begin
      bus_d = bus_q;
      rdata_d = rdata_q;
      case (bus_q)
         icr_pkg::ICR_BUS_IDLE: begin
            if (req_v) begin
               bus_d = icr_pkg::ICR_BUS_ACK;
               rdata_d = {24'h000000, rd_mux};
            end
         end
         icr_pkg::ICR_BUS_ACK: begin
            bus_d = icr_pkg::ICR_BUS_IDLE;
         end
         default: begin
            bus_d = icr_pkg::ICR_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= icr_pkg::ICR_BUS_IDLE;
         rdata_q <= 32'h00000000;
      end else begin
         bus_q <= bus_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata = rdata_q;

   // events
   logic ev_t0;
   logic ev_e0;
   logic mismatch;
   logic ev_pc;
   logic [2:0] ev_vec;

   assign ev_t0 = timer0_overflow;
   assign ev_e0 = ext0_e.hit;
   assign mismatch = (pb_sync != snap_q);
   assign ev_pc = mismatch & ~mism_q;
   assign ev_vec = {ev_pc, ev_e0, ev_t0};

   // global enable clear on interrupt entry
   logic clr_high;
   logic clr_low;

   always_comb begin
      clr_high = 1'b0;
      clr_low = 1'b0;
      if (irq_taken) begin
         if (!priority_mode_enable || irq_taken_high) begin
            clr_high = 1'b1;
         end else begin
            clr_low = 1'b1;
         end
      end
   end

   // register next values; hardware sets win over software clears
   always_comb begin
      main_d = main_q;
      second_d = second_q;
      status_d = status_q;
      mask_d = mask_q;
      snap_d = snap_q;
      mism_d = mismatch;
      if (wr_fire && sel_main) begin
         main_d = wd;
      end
      if (wr_fire && sel_second) begin
         second_d = wd & icr_pkg::SECOND_IMPL;
      end
      if (ev_t0) begin
         main_d[icr_pkg::B_T0_FLAG] = 1'b1;
      end
      if (ev_e0) begin
         main_d[icr_pkg::B_E0_FLAG] = 1'b1;
      end
      if (mismatch) begin
         main_d[icr_pkg::B_PC_FLAG] = 1'b1;
      end
      if (clr_high) begin
         main_d[icr_pkg::B_GIE_HIGH] = 1'b0;
      end
      if (clr_low) begin
         main_d[icr_pkg::B_PERIPH_LOW] = 1'b0;
      end
      if (wr_fire && sel_status) begin
         status_d = status_q & ~wd[2:0];
      end
      status_d = status_d | ev_vec;
      if (wr_fire && sel_mask) begin
         mask_d = wd[2:0];
      end
      if (port_b_read) begin
         snap_d = pb_sync;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_q <= icr_pkg::MAIN_RST;
         second_q <= icr_pkg::SECOND_RST;
         status_q <= icr_pkg::STATUS_RST;
         mask_q <= icr_pkg::MASK_RST;
         snap_q <= 4'h0;
         mism_q <= 1'b0;
      end else begin
         main_q <= main_d;
         second_q <= second_d;
         status_q <= status_d;
         mask_q <= mask_d;
         snap_q <= snap_d;
         mism_q <= mism_d;
      end
   end

   // vectoring requests
   logic gie_high;
   logic periph_low;
   logic pend_t0;
   logic pend_e0;
   logic pend_pc;
   logic t0_prio;
   logic pc_prio;
   logic hi_src;
   logic lo_src;
   logic req_high_q;
   logic req_high_d;
   logic req_low_q;
   logic req_low_d;
   logic [7:0] pullup_q;
   logic [7:0] pullup_d;
   logic irq_q;
   logic irq_d;

   assign gie_high = main_q[icr_pkg::B_GIE_HIGH];
   assign periph_low = main_q[icr_pkg::B_PERIPH_LOW];
   assign pend_t0 = main_q[icr_pkg::B_T0_FLAG] & main_q[icr_pkg::B_T0_EN];
   assign pend_e0 = main_q[icr_pkg::B_E0_FLAG] & main_q[icr_pkg::B_E0_EN];
   assign pend_pc = main_q[icr_pkg::B_PC_FLAG] & main_q[icr_pkg::B_PC_EN];
   assign t0_prio = second_q[icr_pkg::B_T0_PRIO];
   assign pc_prio = second_q[icr_pkg::B_PC_PRIO];

   // ext0 has no priority bit and is always high level
   assign hi_src = (pend_t0 & t0_prio) | pend_e0 | (pend_pc & pc_prio) | periph_pend_high;
   assign lo_src = (pend_t0 & ~t0_prio) | (pend_pc & ~pc_prio) | periph_pend_low;

   always_comb begin
      req_high_d = 1'b0;
      req_low_d = 1'b0;
      if (priority_mode_enable) begin
         req_high_d = gie_high & hi_src;
         req_low_d = gie_high & periph_low & lo_src;
      end else begin
         // all sources to one level, priority bits ignored
         req_high_d = gie_high & (pend_t0 | pend_e0 | pend_pc
                      | (periph_low & (periph_pend_high | periph_pend_low)));
      end
      // entry clears the enable this cycle, so drop the request too
      if (irq_taken) begin
         req_high_d = 1'b0;
         req_low_d = 1'b0;
      end
      if (second_q[icr_pkg::B_PULLUP_DIS]) begin
         pullup_d = 8'h00;
      end else begin
         pullup_d = port_b_latch;
      end
      irq_d = |(status_q & mask_q);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_high_q <= 1'b0;
         req_low_q <= 1'b0;
         pullup_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         req_high_q <= req_high_d;
         req_low_q <= req_low_d;
         pullup_q <= pullup_d;
         irq_q <= irq_d;
      end
   end

   assign irq_req_high = req_high_q;
   assign irq_req_low = req_low_q;
   assign port_b_pullup_en = pullup_q;
   assign ext1_edge_select = second_q[icr_pkg::B_E1_EDGE];
   assign irq = irq_q;

endmodule
`default_nettype wire

// File: testbench/icr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module icr_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [7:0] port_b_latch,
   input wire logic [7:0] port_b_pullup_en,
   input wire logic priority_mode_enable,
   input wire logic irq_taken,
   input wire logic irq_req_high,
   input wire logic irq_req_low
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_req_new;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   a_wait_one: assert property (s_req_new |-> s_one_wait)
      else $error("answer not after one wait state");
   a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_rdata_hold: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
      else $error("read data moved while idle");
   a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait raised while idle");
   a_pullup_src: assert property (port_b_pullup_en != 8'h00 |-> port_b_pullup_en == $past(port_b_latch))
      else $error("pull-ups not from latch");
   a_taken_clr: assert property (irq_taken |=> !irq_req_high && !irq_req_low)
      else $error("request kept after take");
   a_compat_low: assert property (!priority_mode_enable [*2] |-> !irq_req_low)
      else $error("low request in compat mode");
   a_low_mode: assert property (irq_req_low |-> $past(priority_mode_enable))
      else $error("low request without priority mode");
endmodule
bind icr_top icr_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .port_b_latch(port_b_latch), .port_b_pullup_en(port_b_pullup_en),
   .priority_mode_enable(priority_mode_enable), .irq_taken(irq_taken),
   .irq_req_high(irq_req_high), .irq_req_low(irq_req_low));
`default_nettype wire

// File: testbench/icr_partner.sv
`timescale 1ns/1ps
`default_nettype none
module icr_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic irq_req_high,
   input wire logic irq_req_low,
   input wire logic take_en,
   input wire logic slow,
   output logic irq_taken,
   output logic irq_taken_high
);
   logic [2:0] wait_q;
   // vectors 2 or 7 cycles after a request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 3'h0;
         irq_taken <= 1'b0;
         irq_taken_high <= 1'b0;
      end else begin
         irq_taken <= 1'b0;
         if (!take_en || irq_taken || !(irq_req_high || irq_req_low)) begin
            wait_q <= 3'h0;
         end else if (wait_q == (slow ? 3'h6 : 3'h1)) begin
            wait_q <= 3'h0;
            irq_taken <= 1'b1;
            irq_taken_high <= irq_req_high;
         end else begin
            wait_q <= wait_q + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb_interrupt_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_control_regs;
   logic clk, rst_n, rd, wr, tov, pin, pbr, pm, pph, ppl, tk, slow;
   logic wq, tkn, tkh, rqh, rql, e1, irq;
   logic [4:0] adr;
   logic [31:0] wd, rdat;
   logic [3:0] be, pbu;
   logic [7:0] lat, pu, q, v;
   int fail_count, check_count, seed, tn, i;
   int cyc = 0;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   icr_top dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
      .timer0_overflow(tov), .ext0_pin(pin), .port_b_a_upper(pbu), .port_b_read(pbr),
      .port_b_latch(lat), .priority_mode_enable(pm), .periph_pend_high(pph),
      .periph_pend_low(ppl), .irq_taken(tkn), .irq_taken_high(tkh), .irq_req_high(rqh),
      .irq_req_low(rql), .port_b_pullup_en(pu), .ext1_edge_select(e1), .irq(irq));
   icr_partner cpu (.clk(clk), .rst_n(rst_n), .irq_req_high(rqh), .irq_req_low(rql),
      .take_en(tk), .slow(slow), .irq_taken(tkn), .irq_taken_high(tkh));
   function automatic logic [7:0] pu_exp(input logic [7:0] s, input logic [7:0] l);
      return s[icr_pkg::B_PULLUP_DIS] ? 8'h00 : l;
   endfunction
   function automatic logic [7:0] taken(input logic [7:0] m, input logic hi);
      return hi ? (m & 8'h7F) : (m & 8'hBF);
   endfunction
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wd <= {24'h0, d};
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wq !== 1'b0) @(posedge clk);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      ck(q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic t);
      @(posedge clk);
      if (t) tov <= 1'b1;
      else pbr <= 1'b1;
      @(posedge clk);
      tov <= 1'b0;
      pbr <= 1'b0;
   endtask
   task automatic fin;
      tn++;
      $display("test %0d ends", tn);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         complete_run;
      end
   end
   initial begin
      seed = 32'hb9be;
      {rd, wr, tov, pin, pbr, pm, pph, ppl, tk, slow} = '0;
      adr = '0;
      wd = '0;
      be = 4'hF;
      pbu = '0;
      lat = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rc(5'h00, 8'h00);
      rc(5'h04, 8'hE5);
      ck(pu, 8'h00);
      ck({7'h0, e1}, 8'h01);
      rc(5'h08, 8'h00);
      rc(5'h0C, 8'h00);
      bus(1'b1, 5'h10, 8'hFF);
      rc(5'h10, 8'h00);
      fin;
      for (i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         bus(1'b1, 5'h00, v & 8'hF8);
         rc(5'h00, v & 8'hF8);
         bus(1'b1, 5'h04, v);
         lat <= v ^ 8'h5A;
         rc(5'h04, v & 8'hE5);
         ck(pu, pu_exp(v, v ^ 8'h5A));
         ck({7'h0, e1}, {7'h0, v[5]});
      end
      bus(1'b1, 5'h00, 8'h00);
      be <= 4'hE;
      bus(1'b1, 5'h00, 8'hF8);
      be <= 4'hF;
      rc(5'h00, 8'h00);
      fin;
      bus(1'b1, 5'h0C, 8'h01);
      pulse(1'b1);
      idle(8);
      ck({7'h0, irq}, 8'h01);
      rc(5'h00, 8'h04);
      bus(1'b1, 5'h0C, 8'h00);
      idle(2);
      ck({7'h0, irq}, 8'h00);
      bus(1'b1, 5'h0C, 8'h01);
      bus(1'b1, 5'h08, 8'h01);
      idle(2);
      ck({7'h0, irq}, 8'h00);
      bus(1'b1, 5'h00, 8'h00);
      rc(5'h00, 8'h00);
      fin;
      for (i = 0; i < 2; i++) begin
         bus(1'b1, 5'h04, i ? 8'hA5 : 8'hE5);
         pin <= i[0];
         idle(6);
         bus(1'b1, 5'h00, 8'h00);
         pin <= !i[0];
         idle(6);
         rc(5'h00, 8'h02);
         bus(1'b1, 5'h00, 8'h00);
         pin <= i[0];
         idle(6);
         rc(5'h00, 8'h00);
      end
      pulse(1'b0);
      pbu <= 4'h1 | 4'($random(seed));
      idle(6);
      bus(1'b1, 5'h00, 8'h00);
      rc(5'h00, 8'h01);
      pulse(1'b0);
      idle(4);
      bus(1'b1, 5'h00, 8'h00);
      rc(5'h00, 8'h00);
      rc(5'h08, 8'h06);
      fin;
      tk <= 1'b1;
      slow <= 1'b1;
      bus(1'b1, 5'h00, 8'hA0);
      pulse(1'b1);
      idle(2);
      ck({7'h0, rqh}, 8'h01);
      idle(10);
      ck({7'h0, rql}, 8'h00);
      rc(5'h00, taken(8'hA4, 1'b1));
      bus(1'b1, 5'h00, 8'h00);
      pm <= 1'b1;
      slow <= 1'b0;
      bus(1'b1, 5'h04, 8'hE1);
      bus(1'b1, 5'h00, 8'hE0);
      pulse(1'b1);
      idle(2);
      ck({7'h0, rql}, 8'h01);
      ck({7'h0, rqh}, 8'h00);
      idle(6);
      rc(5'h00, taken(8'hE4, 1'b0));
      pph <= 1'b1;
      idle(8);
      rc(5'h00, taken(8'hA4, 1'b1));
      pph <= 1'b0;
      fin;
      complete_run;
   end
endmodule
`default_nettype wire
